// *** hdl/cspt_regs.vh ***
// register offsets, field positions, reset values and timing counts of the clock control block
`ifndef CSPT_REGS_VH
`define CSPT_REGS_VH

// ------------------------------------------------------------
// register map (byte addresses on the plain register port)
// ------------------------------------------------------------
`define CSPT_ADDR_RC_TRIM      4'h0
`define CSPT_ADDR_PLL_CTRL     4'h1
`define CSPT_ADDR_CLK_STATUS   4'h2
`define CSPT_ADDR_SLEEP_CTRL   4'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CSPT_TRIM_RANGE_BIT    7
`define CSPT_PLL_LOCK_BIT      0
`define CSPT_PLL_ON_BIT        1
`define CSPT_PLL_RATE_BIT      2
`define CSPT_ST_SYSREADY_BIT   0
`define CSPT_ST_FASTCLK_BIT    1
`define CSPT_ST_RCRUN_BIT      2
`define CSPT_ST_XOSCRUN_BIT    3
`define CSPT_ST_WDOGRUN_BIT    4
`define CSPT_ST_BADCFG_BIT     5

// ------------------------------------------------------------
// reset values, fuse codes and sleep mode codes
// ------------------------------------------------------------
`define CSPT_PLL_CTRL_RESET    8'h00
`define CSPT_SRC_EXT_CLK       4'h0
`define CSPT_SRC_PLL_EXT_CLK   4'h1
`define CSPT_SRC_RC            4'h2
`define CSPT_SRC_PLL_RC        4'h3
`define CSPT_SRC_PLL_EXT_OSC   4'h5
`define CSPT_SLEEP_POWER_DOWN  3'h2
`define CSPT_SLEEP_STANDBY     3'h6

// ------------------------------------------------------------
// timing: times in their own units, cycle counts derived at 100 MHz
// ------------------------------------------------------------
`define CSPT_CLK_MHZ           100
`define CSPT_LOCK_TIME_MS      100
`define CSPT_LOCK_CYCLES       (`CSPT_LOCK_TIME_MS * 1000 * `CSPT_CLK_MHZ)
`define CSPT_DLY_4MS_US        4000
`define CSPT_DLY_4P1MS_US      4100
`define CSPT_DLY_64MS_US       64000
`define CSPT_DLY_65MS_US       65000
`define CSPT_DLY_4MS_CYC       (`CSPT_DLY_4MS_US * `CSPT_CLK_MHZ)
`define CSPT_DLY_4P1MS_CYC     (`CSPT_DLY_4P1MS_US * `CSPT_CLK_MHZ)
`define CSPT_DLY_64MS_CYC      (`CSPT_DLY_64MS_US * `CSPT_CLK_MHZ)
`define CSPT_DLY_65MS_CYC      (`CSPT_DLY_65MS_US * `CSPT_CLK_MHZ)
`define CSPT_CK_6              6
`define CSPT_CK_14             14
`define CSPT_CK_1K             1024
`define CSPT_CK_16K            16384
`define CSPT_WDOG_KHZ          128
`define CSPT_WDOG_DIV          ((`CSPT_CLK_MHZ * 1000) / (2 * `CSPT_WDOG_KHZ))
`define CSPT_PLL_REF_DIV       8
`define CSPT_PLL_MULT          64

`endif

// *** hdl/cspt_clock_control.v ***
// clock source selection, rc trim, pll control/status, start-up delays, clock out and watchdog clock
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cspt_regs.vh"

// Function
// RULE1 - reset loads factory trim into trim register
// RULE2 - trim is 8-bit, writable anytime, retunes oscillator
// RULE3 - top trim bit picks low/high overlapping range
// RULE4 - low seven bits tune monotonically within range
// RULE5 - software keeps trim below 8.8 MHz during writes
// RULE6 - pll multiplies 1 MHz reference (source/8) by 64
// RULE7 - pll runs on enable bit; lock flag bit 0
// RULE8 - rate bit selects 64 or 32 MHz
// RULE9 - enabling pll also starts rc reference
// RULE10 - enable bit reads 1 when pll is system clock
// RULE11 - lock takes 100 ms; fast clock after lock
// RULE12 - pll register bits 7..3 read zero
// RULE13 - oscillators and pll off in deep sleeps
// RULE14 - pll on rc start-up delays per code
// RULE15 - pll on external oscillator start-up delays
// RULE16 - pll on external clock: 6 cycles, 11 reserved
// RULE17 - fuses 0000 select external clock input
// RULE18 - external clock delays 6 CK, 4.1/65 ms
// RULE19 - external clock changes under 2% per cycle
// RULE20 - clock-out fuse drives clock out, even in reset
// RULE21 - 128 kHz oscillator clocks the watchdog; code ticks every 390 system clocks, about 256 kHz
// RULE22 - trim above 8 MHz loses pll lock
// RULE23 - fuses 0010 select internal rc oscillator
// RULE24 - lock flag zero and cleared while disabled
module cspt_clock_control #(
	parameter [31:0] LOCK_CYCLES   = `CSPT_LOCK_CYCLES,
	parameter [31:0] DLY_4MS_CYC   = `CSPT_DLY_4MS_CYC,
	parameter [31:0] DLY_4P1MS_CYC = `CSPT_DLY_4P1MS_CYC,
	parameter [31:0] DLY_64MS_CYC  = `CSPT_DLY_64MS_CYC,
	parameter [31:0] DLY_65MS_CYC  = `CSPT_DLY_65MS_CYC,
	parameter [31:0] CK_16K        = `CSPT_CK_16K,
	parameter [7:0]  FACTORY_TRIM  = 8'h80,
	parameter [7:0]  TRIM_8MHZ_MAX = 8'hbf
) (
	input  wire        i_sys_clk,
	input  wire        i_reset,
	input  wire [3:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire [3:0]  i_clock_source_fuses,
	input  wire [1:0]  i_startup_delay_fuses,
	input  wire        i_clock_out_fuse,
	input  wire        i_external_clock_input,
	input  wire        i_wake,
	output reg  [7:0]  o_rdata,
	output reg  [7:0]  o_rc_trim_value,
	output reg         o_rc_run,
	output reg         o_xosc_run,
	output reg         o_pll_run,
	output reg         o_pll_rate_select,
	output reg         o_fast_peripheral_clock,
	output reg         o_sys_ready,
	output reg         o_clock_out_pin,
	output reg         o_clock_out_oe,
	output reg         o_wdog_tick
);

	// ------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------
	localparam [1:0] ST_RESET_DLY = 2'h0;
	localparam [1:0] ST_RUN       = 2'h1;
	localparam [1:0] ST_SLEEP     = 2'h2;
	localparam [1:0] ST_WAKE_DLY  = 2'h3;

	// ------------------------------------------------------------
	// registers and internal signals
	// ------------------------------------------------------------
	reg  [7:0]  rc_trim_value;
	reg         pll_turn_on;
	reg         pll_rate_select;
	reg         pll_locked_flag;
	reg  [31:0] lock_cnt;
	reg  [2:0]  sleep_mode;
	reg         sleep_req;
	reg  [1:0]  state;
	reg  [31:0] dly_cnt;
	reg         ext_s1;
	reg         ext_s2;
	reg         ext_prev;
	reg  [3:0]  fuse_src;
	reg  [1:0]  fuse_sut;
	reg         fuse_clock_out_fuse;
	reg         fuses_taken;
	reg  [15:0] wdog_cnt;
	wire        clock_out_fuse_en;
	reg  [31:0] next_dly;
	reg  [31:0] wake_dly;
	reg         bad_cfg;
	wire        pll_is_sys;
	wire        deep_sleep_state;
	wire        pll_enable_eff;
	wire        ext_edge;
	wire        ext_counted;
	wire [7:0]  pll_reg_rd;

	// pll as system source forces the enable bit on
	assign pll_is_sys = (fuse_src == `CSPT_SRC_PLL_RC) || (fuse_src == `CSPT_SRC_PLL_EXT_OSC) ||
		(fuse_src == `CSPT_SRC_PLL_EXT_CLK);                                        // [RULE10]
	assign deep_sleep_state = (state == ST_SLEEP) &&
		((sleep_mode == `CSPT_SLEEP_POWER_DOWN) || (sleep_mode == `CSPT_SLEEP_STANDBY));
	assign pll_enable_eff = (pll_turn_on | pll_is_sys) & ~deep_sleep_state;         // [RULE7] [RULE13]
	assign pll_reg_rd = {5'h00, pll_rate_select, pll_turn_on | pll_is_sys,
		pll_locked_flag};                                                            // [RULE12]
	// external clock edges, counted only when it is the source
	assign ext_edge = ext_s2 & ~ext_prev;
	assign ext_counted = (fuse_src == `CSPT_SRC_EXT_CLK) || (fuse_src == `CSPT_SRC_PLL_EXT_CLK);
	// pin strap until the fuses are captured, so clock out never drops at reset release
	assign clock_out_fuse_en = fuses_taken ? fuse_clock_out_fuse : i_clock_out_fuse;

	// ------------------------------------------------------------
	// fuse capture: straps taken on the first clock after reset release
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			fuse_src    <= `CSPT_SRC_RC;
			fuse_sut    <= 2'h0;
			fuse_clock_out_fuse  <= 1'b0;
			fuses_taken <= 1'b0;
		end else if (!fuses_taken) begin
			fuse_src    <= i_clock_source_fuses;                        // [RULE17] [RULE23]
			fuse_sut    <= i_startup_delay_fuses;
			fuse_clock_out_fuse  <= i_clock_out_fuse;
			fuses_taken <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// external clock pin synchroniser; the first stage feeds only the second
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			ext_s1   <= 1'b0;
			ext_s2   <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_s1   <= i_external_clock_input;
			ext_s2   <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	// ------------------------------------------------------------
	// start-up delay tables, chosen by source code and delay code
	// ------------------------------------------------------------
	always @* begin
		next_dly = `CSPT_CK_14;
		wake_dly = `CSPT_CK_6;
		bad_cfg  = 1'b0;
		case (fuse_src)
			`CSPT_SRC_PLL_RC: begin
				wake_dly = (fuse_sut == 2'h3) ? CK_16K : `CSPT_CK_1K;           // [RULE14]
				case (fuse_sut)
					2'h1:    next_dly = `CSPT_CK_14 + DLY_4MS_CYC;
					2'h2:    next_dly = `CSPT_CK_14 + DLY_64MS_CYC;
					default: next_dly = `CSPT_CK_14;
				endcase
			end
			`CSPT_SRC_PLL_EXT_OSC: begin
				wake_dly = fuse_sut[1] ? CK_16K : `CSPT_CK_1K;                   // [RULE15]
				case (fuse_sut)
					2'h1, 2'h2: next_dly = `CSPT_CK_14 + DLY_4MS_CYC;
					2'h3:    next_dly = `CSPT_CK_14 + DLY_64MS_CYC;
					default: next_dly = `CSPT_CK_14;
				endcase
			end
			`CSPT_SRC_PLL_EXT_CLK: begin
				wake_dly = `CSPT_CK_6;                                           // [RULE16]
				bad_cfg  = (fuse_sut == 2'h3);
				case (fuse_sut)
					2'h1:    next_dly = `CSPT_CK_14 + DLY_4MS_CYC;
					2'h2:    next_dly = `CSPT_CK_14 + DLY_64MS_CYC;
					default: next_dly = `CSPT_CK_14;
				endcase
			end
			default: begin
				// external clock and rc share the 6 CK / 4.1 ms / 65 ms table
				wake_dly = `CSPT_CK_6;                                           // [RULE18]
				bad_cfg  = (fuse_sut == 2'h3);
				case (fuse_sut)
					2'h1:    next_dly = `CSPT_CK_14 + DLY_4P1MS_CYC;
					2'h2:    next_dly = `CSPT_CK_14 + DLY_65MS_CYC;
					default: next_dly = `CSPT_CK_14;
				endcase
			end
		endcase
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			rc_trim_value   <= FACTORY_TRIM;                                     // [RULE1]
			pll_turn_on     <= 1'b0;
			pll_rate_select <= 1'b0;
			sleep_mode      <= 3'h0;
			sleep_req       <= 1'b0;
		end else begin
			sleep_req <= 1'b0;
			if (i_wr) begin
				case (i_addr)
					`CSPT_ADDR_RC_TRIM: rc_trim_value <= i_wdata;                // [RULE2]
					`CSPT_ADDR_PLL_CTRL: begin
						pll_rate_select <= i_wdata[`CSPT_PLL_RATE_BIT];          // [RULE8]
						pll_turn_on     <= i_wdata[`CSPT_PLL_ON_BIT];            // [RULE9]
					end
					`CSPT_ADDR_SLEEP_CTRL: begin
						sleep_mode <= i_wdata[3:1];
						sleep_req  <= i_wdata[0];
					end
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// lock detector model: counts lock time from enable; trim above 8 MHz
	// pushes the reference out of range and the loop drops lock
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			lock_cnt        <= 32'h0000_0000;
			pll_locked_flag <= 1'b0;
		end else if (!pll_enable_eff) begin
			lock_cnt        <= 32'h0000_0000;                                    // [RULE24]
			pll_locked_flag <= 1'b0;
		end else if ((fuse_src == `CSPT_SRC_PLL_RC || !pll_is_sys) && (rc_trim_value > TRIM_8MHZ_MAX)) begin
			lock_cnt        <= 32'h0000_0000;                                    // [RULE22]
			pll_locked_flag <= 1'b0;
		end else if (lock_cnt >= LOCK_CYCLES - 32'h1) begin
			pll_locked_flag <= 1'b1;                                             // [RULE11]
		end else begin
			lock_cnt <= lock_cnt + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// start-up / sleep sequencer; external clock delays count pin edges
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state   <= ST_RESET_DLY;
			dly_cnt <= 32'h0000_0000;
		end else begin
			case (state)
				ST_RESET_DLY, ST_WAKE_DLY: begin
					if (!fuses_taken) begin
						dly_cnt <= 32'h0000_0000;
					end else if (dly_cnt >= ((state == ST_RESET_DLY) ? next_dly : wake_dly) - 32'h1) begin
						state   <= ST_RUN;
						dly_cnt <= 32'h0000_0000;
					end else if (!ext_counted || ext_edge) begin
						dly_cnt <= dly_cnt + 32'h1;                                  // [RULE16] [RULE18]
					end
				end
				ST_RUN: begin
					if (sleep_req) begin
						state <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (i_wake) begin
						state <= ST_WAKE_DLY;                                        // [RULE13]
					end
				end
				default: state <= ST_RESET_DLY;
			endcase
		end
	end

	// ------------------------------------------------------------
	// watchdog enable divider, one tick every 390 cycles (about 256 kHz); the system clock divider for clock out is the next block
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			wdog_cnt    <= 16'h0000;
			o_wdog_tick <= 1'b0;
		end else begin
			if (wdog_cnt == `CSPT_WDOG_DIV - 1) begin
				wdog_cnt    <= 16'h0000;
				o_wdog_tick <= 1'b1;                                             // [RULE21]
			end else begin
				wdog_cnt    <= wdog_cnt + 16'h0001;
				o_wdog_tick <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// clock out runs during reset too, so it sits outside the reset branch
	// ------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		// the pin divides itself, so it keeps toggling through reset; low while disabled
		o_clock_out_pin <= clock_out_fuse_en & ~o_clock_out_pin;                              // [RULE20]
		o_clock_out_oe  <= clock_out_fuse_en;
	end

	// ------------------------------------------------------------
	// registered outputs and read data
	// ------------------------------------------------------------
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata                 <= 8'h00;
			o_rc_trim_value         <= FACTORY_TRIM;
			o_rc_run                <= 1'b1;
			o_xosc_run              <= 1'b0;
			o_pll_run               <= 1'b0;
			o_pll_rate_select       <= 1'b0;
			o_fast_peripheral_clock <= 1'b0;
			o_sys_ready             <= 1'b0;
		end else begin
			o_rc_trim_value   <= rc_trim_value;                                  // [RULE3] [RULE4]
			o_rc_run          <= ~deep_sleep_state & ((fuse_src == `CSPT_SRC_RC) ||
				(fuse_src == `CSPT_SRC_PLL_RC) || pll_enable_eff);                 // [RULE9] [RULE23]
			o_xosc_run        <= ~deep_sleep_state && (fuse_src == `CSPT_SRC_PLL_EXT_OSC);
			o_pll_run         <= pll_enable_eff;                                 // [RULE6]
			o_pll_rate_select <= pll_rate_select;
			o_fast_peripheral_clock <= pll_enable_eff & pll_locked_flag;         // [RULE11]
			o_sys_ready       <= (state == ST_RUN);
			o_rdata           <= 8'h00;
			if (i_rd) begin
				case (i_addr)
					`CSPT_ADDR_RC_TRIM:    o_rdata <= rc_trim_value;
					`CSPT_ADDR_PLL_CTRL:   o_rdata <= pll_reg_rd;
					`CSPT_ADDR_CLK_STATUS: o_rdata <= {2'h0, bad_cfg, 1'b1, o_xosc_run, o_rc_run,
						pll_enable_eff & pll_locked_flag, state == ST_RUN};
					`CSPT_ADDR_SLEEP_CTRL: o_rdata <= {4'h0, sleep_mode, 1'b0};
					default:               o_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // cspt_clock_control
`default_nettype wire

// *** sim/cspt_clock_control_checker.sv ***
// port-level assertions for the clock control block
`timescale 1ns/1ns
`default_nettype none
module cspt_clock_control_checker (
	input wire logic       i_sys_clk,
	input wire logic       i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [3:0] i_clock_source_fuses,
	input wire logic [1:0] i_startup_delay_fuses,
	input wire logic       i_clock_out_fuse,
	input wire logic       i_external_clock_input,
	input wire logic       i_wake,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_rc_trim_value,
	input wire logic       o_rc_run,
	input wire logic       o_xosc_run,
	input wire logic       o_pll_run,
	input wire logic       o_pll_rate_select,
	input wire logic       o_fast_peripheral_clock,
	input wire logic       o_sys_ready,
	input wire logic       o_clock_out_pin,
	input wire logic       o_clock_out_oe,
	input wire logic       o_wdog_tick
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [8:0] tick_gap;
	logic       tick_seen;
	logic       pll_fuse;

	// the first tick after reset has no reference, so the gap is judged from the second on
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			tick_gap  <= 9'h000;
			tick_seen <= 1'b0;
		end else if (o_wdog_tick) begin
			tick_gap  <= 9'h000;
			tick_seen <= 1'b1;
		end else begin
			tick_gap <= tick_gap + 9'h001;
		end
	end

	// with a pll source selected the enable bit is pinned high
	assign pll_fuse = (i_clock_source_fuses == 4'h1) || (i_clock_source_fuses == 4'h3) || (i_clock_source_fuses == 4'h5);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	sequence trim_write; i_wr && i_addr == 4'h0; endsequence
	sequence pll_write; i_wr && i_addr == 4'h1; endsequence
	sequence deep_sleep_write;
		i_wr && i_addr == 4'h3 && i_wdata[0] && (i_wdata[3:1] == 3'h2 || i_wdata[3:1] == 3'h6) && !i_wake;
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	trim_update_a: assert property (trim_write |-> ##2 o_rc_trim_value == $past(i_wdata, 2))
		else $error("trim output does not follow write");
	rate_update_a: assert property (pll_write |-> ##2 o_pll_rate_select == $past(i_wdata[2], 2))
		else $error("rate select does not follow write");
	pll_start_a: assert property (pll_write and i_wdata[1] |-> ##2 o_pll_run)
		else $error("pll not started by enable");
	pll_stop_a: assert property (pll_write and !i_wdata[1] && !pll_fuse |-> ##2 !o_pll_run ##1 !o_fast_peripheral_clock)
		else $error("pll or fast clock still on after disable");
	lock_wait_a: assert property ($rose(o_pll_run) |-> !o_fast_peripheral_clock [*8])
		else $error("fast clock before lock time");
	sleep_off_a: assert property (deep_sleep_write |-> ##3 !o_rc_run && !o_xosc_run && !o_pll_run)
		else $error("oscillator running in deep sleep");
	rc_reference_a: assert property (o_pll_run && (i_clock_source_fuses == 4'h2 || i_clock_source_fuses == 4'h3) |-> o_rc_run)
		else $error("pll running without rc reference");
	clk_out_run_a: assert property (i_clock_out_fuse && $past(i_clock_out_fuse) |-> o_clock_out_oe && o_clock_out_pin != $past(o_clock_out_pin))
		else $error("clock out pin not toggling");
	clk_out_off_a: assert property ($stable(i_clock_out_fuse) && !i_clock_out_fuse |-> !o_clock_out_oe)
		else $error("clock out driven without fuse");
	wdog_period_a: assert property (o_wdog_tick && tick_seen |-> tick_gap == 9'h185)
		else $error("watchdog tick period wrong");
	reserved_zero_a: assert property ($past(i_rd) && $past(i_addr) == 4'h1 |-> o_rdata[7:3] == 5'h00)
		else $error("reserved pll bits read nonzero");
endmodule // cspt_clock_control_checker
`default_nettype wire

// *** sim/cspt_ext_clock_model.sv ***
// behavioural model of the external clock driving the clock input pin
`timescale 1ns/1ns
`default_nettype none
module cspt_ext_clock_model #(
	parameter int HALF_NS = 35
) (
	output logic o_clk
);
	// fixed period near 14 MHz: never a step between cycles, inside the accepted range
	initial begin
		o_clk = 1'b0;
		forever #(HALF_NS) o_clk = ~o_clk;
	end
endmodule // cspt_ext_clock_model
`default_nettype wire

// *** sim/cspt_clock_control_tb.sv ***
// self-checking bench for the clock control block
`timescale 1ns/1ns
`default_nettype none
`include "cspt_regs.vh"
module cspt_clock_control_tb;
	logic        i_sys_clk, i_reset, i_wr, i_rd, cko, i_wake, ext_clk;
	logic [3:0]  i_addr, src;
	logic [1:0]  startup_delay_fuses;
	logic [7:0]  i_wdata, o_rdata, trim, v;
	logic        rc_run, xosc_run, pll_run, rate, fast, ready, cko_pin, cko_oe, tick;
	logic [15:0] lfsr;
	int          err_count, check_count, n;
	localparam logic [7:0] CORNER [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	localparam logic [3:0] SRCS [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h2};

	cspt_clock_control #(.LOCK_CYCLES(32'd50), .DLY_4MS_CYC(32'd30), .DLY_4P1MS_CYC(32'd32),
		.DLY_64MS_CYC(32'd36), .DLY_65MS_CYC(32'd38)) cspt_clock_control_i (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .i_clock_source_fuses(src), .i_startup_delay_fuses(startup_delay_fuses), .i_clock_out_fuse(cko),
		.i_external_clock_input(ext_clk), .i_wake(i_wake), .o_rdata(o_rdata), .o_rc_trim_value(trim),
		.o_rc_run(rc_run), .o_xosc_run(xosc_run), .o_pll_run(pll_run), .o_pll_rate_select(rate),
		.o_fast_peripheral_clock(fast), .o_sys_ready(ready), .o_clock_out_pin(cko_pin),
		.o_clock_out_oe(cko_oe), .o_wdog_tick(tick));
	cspt_ext_clock_model cspt_ext_clock_model_i (.o_clk(ext_clk));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so they are sampled there
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata & m, exp);
	endtask

	// bounded wait on ready (0) or fast clock (1); running out ends the run
	task automatic wait_hi(input bit which, input int limit, output int cyc);
		cyc = 0;
		while ((which ? fast : ready) !== 1'b1 && cyc < limit) begin
			@(posedge i_sys_clk);
			#1;
			cyc++;
		end
		if (cyc >= limit) begin
			chk(8'h00, 8'h01);
			print_verdict();
		end
	endtask

	task automatic do_reset(input logic [3:0] s, input logic [1:0] d, input logic c);
		@(posedge i_sys_clk);
		i_reset <= 1'b1;
		src <= s;
		startup_delay_fuses <= d;
		cko <= c;
		repeat (8) @(posedge i_sys_clk);
		i_reset <= 1'b0;
	endtask

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{i_reset, i_wr, i_rd, i_wake, cko, i_addr, i_wdata, src, startup_delay_fuses} = {1'b1, 22'h000000};
		err_count = 0;
		check_count = 0;
		lfsr = 16'hf87a;
		do_reset(`CSPT_SRC_RC, 2'h1, 1'b1);
		wait_hi(1'b0, 500, n);
		rd(`CSPT_ADDR_RC_TRIM, 8'h80);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h00);
		chk({7'h00, cko_oe}, 8'h01);
		// range corners first, then random trims
		for (int k = 0; k < 12; k++) begin
			lfsr = lfsr_next(lfsr);
			v = (k < 4) ? CORNER[k] : lfsr[7:0];
			wr(`CSPT_ADDR_RC_TRIM, v);
			rd(`CSPT_ADDR_RC_TRIM, v);
			chk(trim, v);
		end
		wr(`CSPT_ADDR_RC_TRIM, 8'h80);
		wr(`CSPT_ADDR_PLL_CTRL, 8'hff);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h06);
		chk({6'h00, rate, rc_run}, 8'h03);
		wr(`CSPT_ADDR_PLL_CTRL, 8'h02);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h02);
		chk({6'h00, rate, pll_run}, 8'h01);
		wait_hi(1'b1, 200, n);
		chk({7'h00, n >= 40}, 8'h01);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h03);
		// reference pushed past the top of the band: lock is lost
		wr(`CSPT_ADDR_RC_TRIM, 8'hff);
		repeat (4) @(posedge i_sys_clk);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h02);
		chk({7'h00, fast}, 8'h00);
		wr(`CSPT_ADDR_RC_TRIM, 8'h80); // no memory writes run while trimmed high
		wait_hi(1'b1, 200, n);
		wr(`CSPT_ADDR_PLL_CTRL, 8'h00);
		rd(`CSPT_ADDR_PLL_CTRL, 8'h00);
		wr(`CSPT_ADDR_CLK_STATUS, 8'hff);
		rd(`CSPT_ADDR_CLK_STATUS, 8'h15);
		rd(4'hf, 8'h00);
		// power-down then standby, only on the rc source
		for (int m = 0; m < 2; m++) begin
			wr(`CSPT_ADDR_SLEEP_CTRL, m ? 8'h0d : 8'h05);
			repeat (2) @(posedge i_sys_clk);
			#1;
			chk({4'h0, ready, rc_run, xosc_run, pll_run}, 8'h00);
			@(posedge i_sys_clk);
			i_wake <= 1'b1;
			wait_hi(1'b0, 3000, n);
			@(posedge i_sys_clk);
			i_wake <= 1'b0;
		end
		// each source with a random legal delay code and clock-out setting
		for (int k = 0; k < 5; k++) begin
			lfsr = lfsr_next(lfsr);
			do_reset(SRCS[k], (lfsr[1:0] == 2'h3) ? 2'h2 : lfsr[1:0], lfsr[2]);
			wait_hi(1'b0, 3000, n);
			chk({7'h00, cko_oe}, {7'h00, lfsr[2]});
			wr(`CSPT_ADDR_PLL_CTRL, 8'h00);
			rd(`CSPT_ADDR_PLL_CTRL, {6'h00, k > 0 && k < 4, 1'b0}, 8'h02);
		end
		print_verdict();
	end
endmodule // cspt_clock_control_tb

bind cspt_clock_control cspt_clock_control_checker cspt_clock_control_checker_i (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.i_clock_source_fuses(i_clock_source_fuses), .i_startup_delay_fuses(i_startup_delay_fuses),
	.i_clock_out_fuse(i_clock_out_fuse), .i_external_clock_input(i_external_clock_input), .i_wake(i_wake),
	.o_rdata(o_rdata), .o_rc_trim_value(o_rc_trim_value), .o_rc_run(o_rc_run), .o_xosc_run(o_xosc_run),
	.o_pll_run(o_pll_run), .o_pll_rate_select(o_pll_rate_select), .o_sys_ready(o_sys_ready),
	.o_fast_peripheral_clock(o_fast_peripheral_clock), .o_clock_out_pin(o_clock_out_pin),
	.o_clock_out_oe(o_clock_out_oe), .o_wdog_tick(o_wdog_tick));
`default_nettype wire
